// >>> msc_pkg.sv
// constants for the mode and supply control register bank
package msc_pkg;
    // register addresses, seven bit
    localparam logic [6:0] ADDR_MS      = 7'h01;
    localparam logic [6:0] ADDR_HW      = 7'h02;
    // mode and supply control fields
    localparam int         MODE_HI      = 7;
    localparam int         MODE_LO      = 6;
    localparam int         REG2_HI      = 4;
    localparam int         REG2_LO      = 3;
    localparam int         OV_EN_BIT    = 2;
    localparam int         THR_HI       = 1;
    localparam int         THR_LO       = 0;
    // hardware behaviour control fields
    localparam int         SRO_CFG_BIT  = 6;
    localparam int         FO_SW_BIT    = 5;
    localparam int         WD_CNT_BIT   = 0;
    // writable bits, reserved bits read as zero
    localparam logic [7:0] MS_MASK      = 8'hDF;
    localparam logic [7:0] HW_MASK      = 8'h61;
    // bits kept on restart
    localparam logic [7:0] MS_KEEP      = 8'h03;
    localparam logic [7:0] HW_KEEP      = 8'h41;
    localparam logic [7:0] MS_RESET     = 8'h00;
    localparam logic [7:0] HW_RESET     = 8'h00;
    // mode codes
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_SLEEP   = 2'h1;
    localparam logic [1:0] MODE_STOP    = 2'h2;
    localparam logic [1:0] MODE_SOFTRST = 2'h3;
    // second regulator codes
    localparam logic [1:0] REG2_OFF     = 2'h0;
    localparam logic [1:0] REG2_NORM    = 2'h1;
    localparam logic [1:0] REG2_NSTOP   = 2'h2;
    localparam logic [1:0] REG2_ALWAYS  = 2'h3;
    // watchdog failure counts
    localparam logic [1:0] WD_LIMIT_ONE = 2'h1;
    localparam logic [1:0] WD_LIMIT_TWO = 2'h2;
    // serial frame
    localparam logic [4:0] FRAME_BITS   = 5'h10;
    localparam logic [4:0] ADDR_BITS    = 5'h08;
    // timing
    localparam int         CLK_NS       = 50;
    localparam int         RPIN_LOW_NS  = 2000;
    localparam logic [7:0] RPIN_LOW_CYC = 8'((RPIN_LOW_NS + CLK_NS - 1) / CLK_NS);
    // reset pin sequencer
    typedef enum logic [1:0] {RP_IDLE = 2'b00, RP_LOW = 2'b01} msc_rp_t;
endpackage

// >>> msc_pin_sync.sv
// three stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module msc_pin_sync
    import msc_pkg::*;
#(
    parameter int           W       = 3,
    // stages start at the pin's idle level so no false edge follows reset
    parameter logic [W-1:0] RST_VAL = {W{1'b0}}
)
(
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // pins and filtered levels
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] lvl_out
);
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            // first stage feeds only the second
            always_ff @(posedge clk_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    s1_q <= RST_VAL[i];
                    s2_q <= RST_VAL[i];
                    s3_q <= RST_VAL[i];
                end
                else
                begin
                    s1_q <= pin_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end
            // lvl_out reset value is a constant per pin
            always_ff @(posedge clk_in or posedge rst_in)
            begin
                if (rst_in)
                    lvl_out[i] <= RST_VAL[i];
                else if (s2_q == s3_q)
                    lvl_out[i] <= s3_q;
            end
        end
    endgenerate
endmodule

// >>> msc_spi_shift.sv
// serial frame receiver and reply shifter, lsb first
`timescale 1ns/1ps
module msc_spi_shift
    import msc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // filtered pins
    input  wire logic       sclk_in,
    input  wire logic       cs_n_in,
    input  wire logic       sdi_in,
    // register side
    input  wire logic [7:0] rd_data_in,
    output logic      [6:0] addr_out,
    output logic            wr_out,
    output logic      [7:0] wdata_out,
    output logic            addr_valid_out,
    output logic            frame_done_out,
    output logic            sdo_out,
    output logic            sdo_oe_n_out
);
    logic        sclk_q;
    logic        cs_n_q;
    logic [15:0] rx_q;
    logic [4:0]  cnt_q;
    logic [8:0]  tx_q;
    wire         rise = sclk_in & ~sclk_q & ~cs_n_in;
    wire         fall = ~sclk_in & sclk_q & ~cs_n_in;
    wire         cs_start = ~cs_n_in & cs_n_q;
    wire         cs_end = cs_n_in & ~cs_n_q;
    wire         hit8 = fall && (cnt_q == ADDR_BITS - 5'h01);
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sclk_q         <= 1'b0;
            cs_n_q         <= 1'b1;
            rx_q           <= 16'h0000;
            cnt_q          <= 5'h00;
            tx_q           <= 9'h000;
            addr_out       <= 7'h00;
            wr_out         <= 1'b0;
            wdata_out      <= 8'h00;
            addr_valid_out <= 1'b0;
            frame_done_out <= 1'b0;
            sdo_out        <= 1'b0;
            sdo_oe_n_out   <= 1'b1;
        end
        else
        begin
            sclk_q         <= sclk_in;
            cs_n_q         <= cs_n_in;
            sdo_oe_n_out   <= cs_n_in;
            addr_valid_out <= hit8;
            // short or long frames are dropped
            frame_done_out <= cs_end && (cnt_q == FRAME_BITS);
            if (cs_start)
            begin
                cnt_q <= 5'h00;
                tx_q  <= 9'h000;
            end
            else if (fall)
            begin
                rx_q <= {sdi_in, rx_q[15:1]};
                if (cnt_q != 5'h1F)
                    cnt_q <= cnt_q + 5'h01;
            end
            else if (rise)
                tx_q <= {1'b0, tx_q[8:1]};
            // reply holds the value before any write
            if (addr_valid_out)
                tx_q <= {rd_data_in, tx_q[0]};
            if (hit8)
            begin
                addr_out <= rx_q[15:9];
                wr_out   <= sdi_in;
            end
            if (cs_end)
                wdata_out <= rx_q[15:8];
            sdo_out <= tx_q[0];
        end
    end
endmodule

// >>> msc_ctrl_top.sv
// mode and supply control plus hardware behaviour control registers
// Contract
// - mode field: normal, sleep, stop, soft reset
// - soft reset pulls reset pin unless configured
// - second regulator switch field sets regulator on
// - overvoltage sets flag; reaction only when enabled
// - threshold field selects one of four
// - stop to sleep write is refused
// - restart sets mode field to normal
// - restart and overtemp clear regulator field
// - write reply shows previous register value
// - reserved bits always read zero
// - software bit forces failure outputs on
// - count bit picks first or second failure
// - event driven failure outputs need flag clear
// - restart clears software failure bit
// - reset clears all; restart keeps some bits
// - frame is address, access bit, data byte
// - access bit one writes, zero reads
`timescale 1ns/1ps
module msc_ctrl_top
    import msc_pkg::*;
(
    // clock and reset
    input  wire logic       MCLK_IN,
    input  wire logic       RST_IN,
    // serial pins
    input  wire logic       SCLK_IN,
    input  wire logic       CS_N_IN,
    input  wire logic       SDI_IN,
    output logic            SDO_OUT,
    output logic            SDO_OE_N_OUT,
    // device events
    input  wire logic       RESTART_IN,
    input  wire logic       OVERTEMP_IN,
    input  wire logic       OV_IN,
    input  wire logic       OV_FLAG_CLR_IN,
    input  wire logic       FAILURE_IN,
    input  wire logic       FAILSAFE_IN,
    // device controls
    output logic [1:0]      MODE_OUT,
    output logic            REG2_ON_OUT,
    output logic [1:0]      RST_THR_OUT,
    output logic            OV_FLAG_OUT,
    output logic            OV_REQ_OUT,
    output logic            FAIL_OUTS_OUT,
    output logic            RESET_PIN_N_OUT,
    output logic            SOFT_RESET_OUT,
    output logic [1:0]      WD_LIMIT_OUT
);
    ////////////////////////////////////////////////////////////////////////
    logic [2:0] pin_lvl;
    logic [6:0] addr;
    logic       wr;
    logic [7:0] wdata;
    logic       addr_valid;
    logic       frame_done;
    logic [7:0] ms_q;
    logic [7:0] ms_d;
    logic [7:0] hw_q;
    logic [7:0] hw_d;
    logic       ov_flag_q;
    logic [7:0] rpin_cnt_q;
    logic [7:0] rd_data;
    msc_rp_t    rp_q;

    // link clock idles low, select idles high
    msc_pin_sync #(
        .W       (3),
        .RST_VAL (3'h2)
    ) u_sync (
        .clk_in  (MCLK_IN),
        .rst_in  (RST_IN),
        .pin_in  ({SDI_IN, CS_N_IN, SCLK_IN}),
        .lvl_out (pin_lvl)
    );

    msc_spi_shift u_shift (
        .clk_in         (MCLK_IN),
        .rst_in         (RST_IN),
        .sclk_in        (pin_lvl[0]),
        .cs_n_in        (pin_lvl[1]),
        .sdi_in         (pin_lvl[2]),
        .rd_data_in     (rd_data),
        .addr_out       (addr),
        .wr_out         (wr),
        .wdata_out      (wdata),
        .addr_valid_out (addr_valid),
        .frame_done_out (frame_done),
        .sdo_out        (SDO_OUT),
        .sdo_oe_n_out   (SDO_OE_N_OUT)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode; frame layout and access bit
    wire        sel_ms = (addr == ADDR_MS);
    wire        sel_hw = (addr == ADDR_HW);
    // reply mux reads registers before the frame ends
    assign rd_data = sel_ms ? ms_q : (sel_hw ? hw_q : 8'h00);
    wire        wr_ms = frame_done & wr & sel_ms;
    wire        wr_hw = frame_done & wr & sel_hw;
    wire [1:0]  cur_mode = ms_q[MODE_HI:MODE_LO];
    wire [1:0]  wr_mode = wdata[MODE_HI:MODE_LO];
    // code three starts a soft reset
    wire        soft_rst = wr_ms && (wr_mode == MODE_SOFTRST);
    // mode field left alone on this request
    wire        stop_sleep = wr_ms && (cur_mode == MODE_STOP) && (wr_mode == MODE_SLEEP);
    wire [1:0]  new_mode = stop_sleep ? cur_mode : wr_mode;
    // reserved bits masked away on store
    wire [7:0]  ms_wr_val = {new_mode, wdata[5:0]} & MS_MASK;
    wire [7:0]  hw_wr_val = wdata & HW_MASK;
    // restart keeps threshold only: mode normal, regulator off
    wire [7:0]  ms_rst_val = ms_q & MS_KEEP;
    // restart drops the software failure bit
    wire [7:0]  hw_rst_val = hw_q & HW_KEEP;

    ////////////////////////////////////////////////////////////////////////
    // hardware updates take priority over a write in the same cycle, except a soft reset write, which overrides restart
    always_comb
    begin
        ms_d = ms_q;
        hw_d = hw_q;
        if (soft_rst)
        begin
            ms_d = MS_RESET;
            hw_d = HW_RESET;
        end
        else if (RESTART_IN)
        begin
            ms_d = ms_rst_val;
            hw_d = hw_rst_val;
        end
        else
        begin
            if (wr_ms)
                ms_d = ms_wr_val;
            if (wr_hw)
                hw_d = hw_wr_val;
            if (OVERTEMP_IN)
                ms_d[REG2_HI:REG2_LO] = REG2_OFF;
        end
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            ms_q <= MS_RESET;
            hw_q <= HW_RESET;
        end
        else
        begin
            ms_q <= ms_d;
            hw_q <= hw_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // regulator enable from switch field and current mode
    wire        mode_norm = (cur_mode == MODE_NORMAL);
    wire        mode_stop = (cur_mode == MODE_STOP);
    wire [1:0]  reg2_fld = ms_q[REG2_HI:REG2_LO];
    wire        reg2_on = (reg2_fld == REG2_NORM && mode_norm)
                        | (reg2_fld == REG2_NSTOP && (mode_norm || mode_stop))
                        | (reg2_fld == REG2_ALWAYS && !FAILSAFE_IN);
    // flag set wins over its clear
    wire        ov_flag_d = OV_IN | (ov_flag_q & ~OV_FLAG_CLR_IN);
    // reaction request only when enabled
    wire        ov_req = OV_IN & ms_q[OV_EN_BIT];
    // event driven outputs stay until failure flag clears
    wire        fail_outs = hw_q[FO_SW_BIT] | FAILURE_IN;
    // failure count select
    wire [1:0]  wd_limit = hw_q[WD_CNT_BIT] ? WD_LIMIT_ONE : WD_LIMIT_TWO;
    // pin pulled only when config bit clear
    wire        rpin_pull = soft_rst & ~hw_q[SRO_CFG_BIT];

    always_ff @(posedge MCLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            MODE_OUT       <= MODE_NORMAL;
            REG2_ON_OUT    <= 1'b0;
            RST_THR_OUT    <= 2'h0;
            ov_flag_q      <= 1'b0;
            OV_REQ_OUT     <= 1'b0;
            FAIL_OUTS_OUT  <= 1'b0;
            SOFT_RESET_OUT <= 1'b0;
            WD_LIMIT_OUT   <= WD_LIMIT_TWO;
        end
        else
        begin
            MODE_OUT       <= cur_mode;
            REG2_ON_OUT    <= reg2_on;
            RST_THR_OUT    <= ms_q[THR_HI:THR_LO];
            ov_flag_q      <= ov_flag_d;
            OV_REQ_OUT     <= ov_req;
            FAIL_OUTS_OUT  <= fail_outs;
            SOFT_RESET_OUT <= soft_rst;
            WD_LIMIT_OUT   <= wd_limit;
        end
    end
    assign OV_FLAG_OUT = ov_flag_q;

    ////////////////////////////////////////////////////////////////////////
    // reset pin low for a fixed time after a soft reset
    always_ff @(posedge MCLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            rp_q            <= RP_IDLE;
            rpin_cnt_q      <= 8'h00;
            RESET_PIN_N_OUT <= 1'b1;
        end
        else
        begin
            case (rp_q)
                RP_IDLE:
                begin
                    if (rpin_pull)
                    begin
                        rp_q            <= RP_LOW;
                        rpin_cnt_q      <= RPIN_LOW_CYC - 8'h01;
                        RESET_PIN_N_OUT <= 1'b0;
                    end
                end
                RP_LOW:
                begin
                    // a new soft reset restarts the low time
                    if (rpin_pull)
                        rpin_cnt_q <= RPIN_LOW_CYC - 8'h01;
                    else if (rpin_cnt_q == 8'h00)
                    begin
                        rp_q            <= RP_IDLE;
                        RESET_PIN_N_OUT <= 1'b1;
                    end
                    else
                        rpin_cnt_q <= rpin_cnt_q - 8'h01;
                end
                default:
                begin
                    rp_q            <= RP_IDLE;
                    RESET_PIN_N_OUT <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (RST_IN);

    chk_stop_sleep_refused: assert property (
        stop_sleep && !RESTART_IN |=> ms_q[MODE_HI:MODE_LO] == MODE_STOP)
        else $error("stop to sleep write took effect");

    chk_soft_reset_zero: assert property (
        soft_rst |=> ms_q == MS_RESET && hw_q == HW_RESET && SOFT_RESET_OUT ##1 !SOFT_RESET_OUT)
        else $error("soft reset did not clear registers");

    chk_reset_pin_low: assert property (
        rpin_pull |=> !RESET_PIN_N_OUT [*8])
        else $error("reset pin not held low after soft reset");

    chk_reset_pin_kept: assert property (
        soft_rst && hw_q[SRO_CFG_BIT] && RESET_PIN_N_OUT |=> RESET_PIN_N_OUT)
        else $error("reset pin pulled despite configuration");

    chk_reg2_map: assert property (
        reg2_fld == REG2_OFF || (reg2_fld == REG2_NORM && !mode_norm)
            || (reg2_fld == REG2_NSTOP && !mode_norm && !mode_stop) |=> !REG2_ON_OUT)
        else $error("regulator enable does not follow field");

    chk_ov_flag_set: assert property (
        OV_IN |=> OV_FLAG_OUT)
        else $error("overvoltage flag not set");

    chk_ov_no_react: assert property (
        OV_IN && !ms_q[OV_EN_BIT] |=> !OV_REQ_OUT)
        else $error("overvoltage reaction while disabled");

    chk_thr_follow: assert property (
        $changed(ms_q[THR_HI:THR_LO]) |=> RST_THR_OUT == $past(ms_q[THR_HI:THR_LO]))
        else $error("threshold output lags field");

    chk_restart_clear: assert property (
        RESTART_IN && !soft_rst |=> ms_q[7:2] == 6'h00 && !hw_q[FO_SW_BIT]
            && hw_q[SRO_CFG_BIT] == $past(hw_q[SRO_CFG_BIT]) && ms_q[1:0] == $past(ms_q[1:0]))
        else $error("restart did not update registers");

    chk_temp_reg2_off: assert property (
        OVERTEMP_IN |=> ms_q[REG2_HI:REG2_LO] == REG2_OFF)
        else $error("overtemperature left regulator field set");

    chk_reserved_zero: assert property (
        ms_q[5] == 1'b0 && hw_q[7] == 1'b0 && hw_q[4:1] == 4'h0)
        else $error("reserved bit is set");

    chk_fail_outs: assert property (
        FAILURE_IN || hw_q[FO_SW_BIT] |=> FAIL_OUTS_OUT)
        else $error("failure outputs inactive");

    chk_wd_limit: assert property (
        hw_q[WD_CNT_BIT] |=> WD_LIMIT_OUT == WD_LIMIT_ONE)
        else $error("watchdog count select ignored");

    chk_wd_limit_two: assert property (
        !hw_q[WD_CNT_BIT] |=> WD_LIMIT_OUT == WD_LIMIT_TWO)
        else $error("default watchdog count lost");

    chk_ov_flag_clear: assert property (
        OV_FLAG_CLR_IN && !OV_IN |=> !OV_FLAG_OUT)
        else $error("overvoltage flag not cleared");

    chk_ov_react: assert property (
        OV_IN && ms_q[OV_EN_BIT] |=> OV_REQ_OUT)
        else $error("overvoltage reaction missing");

    chk_restart_mode_out: assert property (
        RESTART_IN && !soft_rst |=> ##1 MODE_OUT == MODE_NORMAL)
        else $error("mode output not normal after restart");

    chk_pin_released: assert property (
        rp_q == RP_IDLE && !rpin_pull |=> RESET_PIN_N_OUT)
        else $error("reset pin low while idle");

    chk_fail_outs_off: assert property (
        !FAILURE_IN && !hw_q[FO_SW_BIT] |=> !FAIL_OUTS_OUT)
        else $error("failure outputs active without cause");

    chk_ms_write: assert property (
        wr_ms && !soft_rst && !stop_sleep && !RESTART_IN && !OVERTEMP_IN |=> ms_q == (wdata & MS_MASK))
        else $error("mode register write not stored");

    chk_read_keeps: assert property (
        frame_done && !wr && !RESTART_IN && !OVERTEMP_IN |=> $stable(ms_q) && $stable(hw_q))
        else $error("read frame changed a register");

    cov_soft_reset: cover property (soft_rst ##1 !RESET_PIN_N_OUT);
    cov_stop_sleep: cover property (stop_sleep);
    cov_restart: cover property (RESTART_IN && hw_q[FO_SW_BIT]);
    cov_hw_write: cover property (wr_hw ##1 hw_q != HW_RESET);
endmodule

// >>> msc_spi_master.sv
// serial link master model standing in for the controller
`timescale 1ns/1ps
module msc_spi_master
(
    // clock
    input  wire logic   clk_in,
    // serial pins
    output logic        sclk_out,
    output logic        cs_n_out,
    output logic        sdi_out,
    input  wire logic   sdo_in,
    // reply of the last frame
    output logic [15:0] reply_out,
    output logic        done_out
);
    // half link period in system clocks, 400 ns link period
    localparam int HALF = 4;

    initial
    begin
        sclk_out  = 1'b0;
        cs_n_out  = 1'b1;
        sdi_out   = 1'b0;
        reply_out = 16'h0000;
        done_out  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // one whole frame, lsb first; link clock stands low between frames
    task automatic xfer(input logic [15:0] cmd);
        logic [15:0] rep;
        cs_n_out = 1'b0;
        tick(HALF);
        for (int i = 0; i < 16; i++)
        begin
            sdi_out  = cmd[i];
            sclk_out = 1'b1;
            tick(HALF);
            sclk_out = 1'b0;
            tick(HALF);
            // sampled late in the low phase: pin filters add delay
            rep[i] = sdo_in;
        end
        cs_n_out  = 1'b1;
        // released line: never leave the last bit standing
        sdi_out   = ~sdi_out;
        reply_out = rep;
        done_out  = 1'b1;
        tick(1);
        done_out  = 1'b0;
    endtask
endmodule

// >>> msc_ctrl_top_test.sv
// self-checking bench for the mode and supply control registers
`timescale 1ns/1ps
module msc_ctrl_top_test;
    import msc_pkg::*;

    logic        clk, rst, restart, overtemp, ov, ovclr, failure, failsafe;
    logic        sclk, cs_n, sdi, sdo, sdo_oe_n, done;
    logic [15:0] reply;
    logic [1:0]  mode, thr, wd_lim;
    logic        reg2_on, ov_flag, ov_req, fail_outs, rpin_n, soft_rst;
    logic [7:0]  ms_m, hw_m;
    logic [31:0] rnd;
    logic [15:0] exp_q[$];
    int          err_total, comparisons, cyc, req_cnt, sr_cnt, rpin_lo, oe_lo;

    msc_ctrl_top uut (.MCLK_IN(clk), .RST_IN(rst), .SCLK_IN(sclk), .CS_N_IN(cs_n), .SDI_IN(sdi),
        .SDO_OUT(sdo), .SDO_OE_N_OUT(sdo_oe_n), .RESTART_IN(restart), .OVERTEMP_IN(overtemp),
        .OV_IN(ov), .OV_FLAG_CLR_IN(ovclr), .FAILURE_IN(failure), .FAILSAFE_IN(failsafe),
        .MODE_OUT(mode), .REG2_ON_OUT(reg2_on), .RST_THR_OUT(thr), .OV_FLAG_OUT(ov_flag),
        .OV_REQ_OUT(ov_req), .FAIL_OUTS_OUT(fail_outs), .RESET_PIN_N_OUT(rpin_n),
        .SOFT_RESET_OUT(soft_rst), .WD_LIMIT_OUT(wd_lim));

    msc_spi_master u_mst (.clk_in(clk), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
        .sdo_in(sdo), .reply_out(reply), .done_out(done));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // event counters and hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (ov_req === 1'b1) req_cnt++;
        if (soft_rst === 1'b1) sr_cnt++;
        if (rpin_n === 1'b0) rpin_lo++;
        if (sdo_oe_n === 1'b0) oe_lo++;
        if (cyc == 20000)
        begin
            err_total++;
            results();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    function automatic logic reg2_exp(input int m, input int r, input logic fs);
        case (r)
            1: return m == 0;
            2: return m != 1;
            3: return !fs;
            default: return 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // frame driver: notes the expected reply, then tracks register contents
    task automatic xf(input logic [6:0] a, input logic w, input logic [7:0] d);
        logic [7:0] cur;
        cur = (a == ADDR_MS) ? ms_m : ((a == ADDR_HW) ? hw_m : 8'h00);
        exp_q.push_back({cur, 8'h00});
        u_mst.xfer({d, w, a});
        if (w && a == ADDR_MS)
        begin
            ms_m = d & MS_MASK;
            if (cur[7:6] == MODE_STOP && d[7:6] == MODE_SLEEP) ms_m[7:6] = MODE_STOP;
            if (d[7:6] == MODE_SOFTRST)
            begin
                ms_m = MS_RESET;
                hw_m = HW_RESET;
            end
        end
        if (w && a == ADDR_HW) hw_m = d & HW_MASK;
        // cs high gap also lets the registers settle
        tick(10);
    endtask

    task automatic pulse(input int k);
        case (k)
            0: restart = 1'b1;
            1: overtemp = 1'b1;
            2: ov = 1'b1;
            default: ovclr = 1'b1;
        endcase
        tick(1);
        {restart, overtemp, ov, ovclr} = 4'h0;
        tick(4);
    endtask

    // reply monitor: oldest note against each finished frame
    initial
    forever
    begin
        @(posedge done);
        #1;
        check(reply, exp_q.pop_front());
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst, restart, overtemp, ov, ovclr, failure, failsafe} = 7'h40;
        {ms_m, hw_m, rnd} = {8'h00, 8'h00, 32'h5c80};
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        tick(12);
        check(16'(rpin_n), 16'h0001);
        check(16'(wd_lim), 16'(WD_LIMIT_TWO));
        check(16'(sdo_oe_n), 16'h0001);
        xf(ADDR_MS, 1'b0, 8'h00);
        check(16'(oe_lo), 16'h0084);
        xf(ADDR_HW, 1'b0, 8'h00);
        xf(7'h03, 1'b0, 8'h00);
        for (int m = 0; m < 3; m++)
            for (int r = 0; r < 4; r++)
            begin
                rnd = xs(rnd);
                failsafe = (r == 3) & rnd[4];
                xf(ADDR_MS, 1'b1, {m[1:0], 1'b0, r[1:0], 1'b0, rnd[1:0]});
                check(16'(mode), 16'(m));
                check(16'(thr), 16'(rnd[1:0]));
                check(16'(reg2_on), 16'(reg2_exp(m, r, failsafe)));
            end
        failsafe = 1'b0;
        xf(ADDR_MS, 1'b1, 8'h40);
        check(16'(mode), 16'(MODE_STOP));
        xf(ADDR_MS, 1'b0, 8'h00);
        for (int e = 0; e < 2; e++)
        begin
            xf(ADDR_MS, 1'b1, {5'h00, e[0], 2'h0});
            req_cnt = 0;
            pulse(2);
            check(16'(ov_flag), 16'h0001);
            check(16'(req_cnt), 16'(e));
            pulse(3);
            check(16'(ov_flag), 16'h0000);
        end
        xf(ADDR_HW, 1'b1, 8'hFF);
        check(16'(wd_lim), 16'(WD_LIMIT_ONE));
        check(16'(fail_outs), 16'h0001);
        xf(ADDR_HW, 1'b0, 8'h00);
        xf(ADDR_MS, 1'b1, 8'h7F);
        pulse(1);
        ms_m[4:3] = REG2_OFF;
        check(16'(reg2_on), 16'h0000);
        xf(ADDR_MS, 1'b0, 8'h00);
        xf(ADDR_MS, 1'b1, 8'h9B);
        pulse(0);
        ms_m &= MS_KEEP;
        hw_m &= HW_KEEP;
        check(16'(mode), 16'(MODE_NORMAL));
        check(16'(fail_outs), 16'h0000);
        xf(ADDR_MS, 1'b0, 8'h00);
        xf(ADDR_HW, 1'b0, 8'h00);
        failure = 1'b1;
        xf(ADDR_HW, 1'b1, 8'h20);
        xf(ADDR_HW, 1'b1, 8'h00);
        check(16'(fail_outs), 16'h0001);
        failure = 1'b0;
        tick(5);
        check(16'(fail_outs), 16'h0000);
        // first soft reset with the reset pin masked, then unmasked
        xf(ADDR_HW, 1'b1, 8'h40);
        for (int s = 0; s < 2; s++)
        begin
            {sr_cnt, rpin_lo} = 64'h0;
            xf(ADDR_MS, 1'b1, 8'hC0);
            tick(60);
            check(16'(sr_cnt), 16'h0001);
            check(16'(rpin_lo), s ? 16'(RPIN_LOW_CYC) : 16'h0000);
            xf(ADDR_MS, 1'b0, 8'h00);
            xf(ADDR_HW, 1'b0, 8'h00);
        end
        results();
    end
endmodule
